// file: rtl/ufc_pkg.sv
package ufc_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] FEAT_OFF    = 8'h00;
   localparam logic [7:0] MODEM_OFF   = 8'h04;
   localparam logic [7:0] INT_EN_OFF  = 8'h08;
   localparam logic [7:0] INT_ST_OFF  = 8'h0C;
   localparam logic [7:0] LINE_OFF    = 8'h10;
   localparam logic [7:0] FCTL_OFF    = 8'h14;
   localparam logic [7:0] HDX_DLY_OFF = 8'h18;
   localparam logic [7:0] RESUME1_OFF = 8'h1C;
   localparam logic [7:0] RESUME2_OFF = 8'h20;
   localparam logic [7:0] PAUSE1_OFF  = 8'h24;
   localparam logic [7:0] PAUSE2_OFF  = 8'h28;
   localparam logic [7:0] STATUS_OFF  = 8'h2C;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int FEAT_AUTO_CTS = 7;
   localparam int FEAT_AUTO_RTS = 6;
   localparam int FEAT_SPECIAL  = 5;
   localparam int FEAT_GATE     = 4;
   localparam int FEAT_TX_DBL   = 3;
   localparam int FEAT_TX_SEND  = 2;
   localparam int FEAT_RX_DBL   = 1;
   localparam int FEAT_RX_SW    = 0;
   localparam int MODEM_RTS     = 1;
   localparam int IE_CTS        = 7;
   localparam int IE_RTS        = 6;
   localparam int IE_PAUSE      = 5;
   localparam int IS_FLOW       = 5;
   localparam int IS_CHAR       = 4;
   localparam int FCTL_HDX      = 3;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [4:0] CHAR_FRAME = 5'h07;  // start, stop, five data bits

   // fill thresholds per trigger select, entry 3 listed first
   localparam logic [3:0][6:0] RTS_OFF_LVL = {7'h3C, 7'h3C, 7'h38, 7'h10};
   localparam logic [3:0][6:0] RTS_ON_LVL  = {7'h38, 7'h10, 7'h08, 7'h00};
   localparam logic [3:0][6:0] PAUSE_LVL   = {7'h3C, 7'h38, 7'h10, 7'h08};
   localparam logic [3:0][6:0] RESUME_LVL  = {7'h38, 7'h10, 7'h08, 7'h00};

   typedef enum logic [1:0] {HDX_IDLE, HDX_SETUP, HDX_SEND, HDX_TURN} ufc_hdx_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } ufc_char_t;

   typedef struct packed {
      logic [7:0]  feat, modem, int_en, line, fctl, hdly;
      logic [7:0]  res1, res2, pau1, pau2;
      logic        sts_flow, sts_char, rts_n, cts_prev, paused, rts_off;
      logic        pend_v, pend_res, defer_v;
      logic [7:0]  pend_c, defer_c;
      ufc_char_t   rx_out;
      logic        sent, snd_v, snd_two;
      logic [4:0]  xcnt;
      logic [7:0]  snd_c0, snd_c1;
      ufc_hdx_t    hst;
      logic [3:0]  hcnt;
      logic        tx_en, tx_hold, tx_empty, irq;
      logic [31:0] prdata;
      logic        pready, pslverr;
   } ufc_state_t;

endpackage

// file: rtl/ufc_flow.sv
// Our own choices: register access over APB and the address map.
module ufc_flow (
   input  wire logic              I_REF_CLK,
   input  wire logic              I_SYS_RST,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire ufc_pkg::ufc_char_t I_RX_CHAR,
   input  wire logic [6:0]        I_RX_LEVEL,
   input  wire logic              I_CTS_N,
   input  wire logic              I_TX_TICK,
   input  wire logic              I_TX_LOAD,
   input  wire logic              I_TX_IDLE,
   input  wire logic              I_HOLD_EMPTY,
   input  wire logic              I_SHIFT_EMPTY,
   input  wire logic              I_FC_DONE,
   output ufc_pkg::ufc_char_t     O_RX_CHAR,
   output ufc_pkg::ufc_char_t     O_FC_SEND,
   output logic                   O_RTS_N,
   output logic                   O_TX_HOLD,
   output logic                   O_TX_ENABLE,
   output logic                   O_TX_EMPTY,
   output logic                   O_IRQ
);
   import ufc_pkg::*;

   ufc_state_t s, n;
   logic [7:0] mask;
   logic [7:0] rd;
   logic       hit;
   logic       cv;
   logic [7:0] cc;
   logic       p_hit, r_hit, store;
   logic       acc, wr;
   logic [1:0] trig;
   logic [4:0] two_chars;
   logic       hdx, rts_act;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // compare only the bits of the selected word length
   function automatic logic eq(input logic [7:0] a, input logic [7:0] b,
                               input logic [7:0] m);
      eq = ((a ^ b) & m) == 8'h00;
   endfunction

   // ----------------------------------------------------------------
   // register read decode
   // ----------------------------------------------------------------
   always_comb begin
      hit = 1'b1;
      rd  = 8'h00;
      unique case (PADDR)
         FEAT_OFF:    rd = s.feat;
         MODEM_OFF:   rd = s.modem;
         INT_EN_OFF:  rd = s.int_en;
         INT_ST_OFF:  rd = {2'h0, s.sts_flow, s.sts_char, 4'h0};
         LINE_OFF:    rd = s.line;
         FCTL_OFF:    rd = s.fctl;
         HDX_DLY_OFF: rd = s.hdly;
         RESUME1_OFF: rd = s.res1;
         RESUME2_OFF: rd = s.res2;
         PAUSE1_OFF:  rd = s.pau1;
         PAUSE2_OFF:  rd = s.pau2;
         STATUS_OFF:  rd = {s.hst, s.sent, s.snd_v, s.rts_off, s.paused,
                            s.tx_hold, s.tx_en};
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n         = s;
      trig      = s.fctl[1:0];
      hdx       = s.fctl[FCTL_HDX];
      mask      = 8'(8'hFF >> (2'h3 - s.line[1:0]));
      two_chars = 5'((5'({3'h0, s.line[1:0]}) + CHAR_FRAME) << 1);
      p_hit     = 1'b0;
      r_hit     = 1'b0;
      store     = 1'b0;

      // apb: one wait state, write lands on the edge that sees pready
      acc = PSEL & PENABLE;
      wr  = acc & s.pready & PWRITE & hit;
      n.pready  = acc & ~s.pready;
      n.pslverr = acc & ~s.pready & ~hit;
      if (acc & ~s.pready) begin
         n.prdata = {24'h0, rd};
      end
      if (wr) begin
         unique case (PADDR)
            FEAT_OFF:    n.feat   = PWDATA[7:0];
            MODEM_OFF:   n.modem  = PWDATA[7:0];
            INT_EN_OFF:  n.int_en = PWDATA[7:0];
            LINE_OFF:    n.line   = PWDATA[7:0];
            FCTL_OFF:    n.fctl   = PWDATA[7:0];
            HDX_DLY_OFF: n.hdly   = PWDATA[7:0];
            RESUME1_OFF: n.res1   = PWDATA[7:0];
            RESUME2_OFF: n.res2   = PWDATA[7:0];
            PAUSE1_OFF:  n.pau1   = PWDATA[7:0];
            PAUSE2_OFF:  n.pau2   = PWDATA[7:0];
            INT_ST_OFF: begin
               // write one to clear; hardware sets below win
               if (PWDATA[IS_FLOW]) n.sts_flow = 1'b0;
               if (PWDATA[IS_CHAR]) n.sts_char = 1'b0;
            end
            default: begin
               n.feat = n.feat;
            end
         endcase
      end

      // receive character path, a deferred char is replayed first
      cv = I_RX_CHAR.valid | s.defer_v;
      cc = s.defer_v ? s.defer_c : I_RX_CHAR.data;
      n.defer_v = 1'b0;
      n.rx_out.valid = 1'b0;
      if (cv) begin
         if (!s.feat[FEAT_RX_SW]) begin
            store = 1'b1;
         end else if (!s.feat[FEAT_RX_DBL]) begin
            p_hit = eq(cc, s.pau1, mask);
            r_hit = eq(cc, s.res1, mask) & ~p_hit;
            store = ~p_hit & ~r_hit;
         end else if (s.pend_v) begin
            n.pend_v = 1'b0;
            if (eq(cc, s.pend_res ? s.res2 : s.pau2, mask)) begin
               p_hit = ~s.pend_res;
               r_hit = s.pend_res;
            end else begin
               // first of pair was data after all: emit it, replay this one
               n.rx_out  = '{valid: 1'b1, data: s.pend_c};
               n.defer_v = 1'b1;
               n.defer_c = cc;
            end
         end else if (eq(cc, s.pau1, mask) | eq(cc, s.res1, mask)) begin
            // hold a possible pair head back from the fifo
            n.pend_v   = 1'b1;
            n.pend_res = ~eq(cc, s.pau1, mask);
            n.pend_c   = cc;
         end else begin
            store = 1'b1;
         end
      end
      if (store) begin
         n.rx_out = '{valid: 1'b1, data: cc};
         if (s.feat[FEAT_SPECIAL] & eq(cc, s.pau2, mask)) begin
            n.sts_char = 1'b1;
         end
      end
      if (p_hit) begin
         n.paused = 1'b1;
         if (s.int_en[IE_PAUSE]) n.sts_char = 1'b1;
      end
      if (r_hit) begin
         n.paused   = 1'b0;
         n.sts_char = 1'b0;
      end
      if (!s.feat[FEAT_RX_SW]) begin
         n.paused = 1'b0;
         n.pend_v = 1'b0;
      end

      // auto rts hysteresis on receive fill
      if (s.feat[FEAT_AUTO_RTS] & s.modem[MODEM_RTS]) begin
         if (I_RX_LEVEL >= RTS_OFF_LVL[trig]) begin
            n.rts_off = 1'b1;
         end else if (I_RX_LEVEL <= RTS_ON_LVL[trig]) begin
            n.rts_off = 1'b0;
         end
      end else begin
         n.rts_off = 1'b0;
      end

      // half duplex direction sequencer, delays in baud ticks
      if (!hdx) begin
         n.hst = HDX_IDLE;
      end else begin
         unique case (s.hst)
            HDX_IDLE: begin
               if (I_TX_LOAD | ~I_TX_IDLE) begin
                  n.hst  = HDX_SETUP;
                  n.hcnt = s.hdly[7:4];
               end
            end
            HDX_SETUP: begin
               if (s.hcnt == 4'h0) begin
                  n.hst = HDX_SEND;
               end else if (I_TX_TICK) begin
                  n.hcnt = s.hcnt - 4'h1;
               end
            end
            HDX_SEND: begin
               if (I_TX_IDLE & ~I_TX_LOAD) begin
                  n.hst  = HDX_TURN;
                  n.hcnt = s.hdly[3:0];
               end
            end
            HDX_TURN: begin
               if (I_TX_LOAD | ~I_TX_IDLE) begin
                  n.hst = HDX_SEND;
               end else if (s.hcnt == 4'h0) begin
                  n.hst = HDX_IDLE;
               end else if (I_TX_TICK) begin
                  n.hcnt = s.hcnt - 4'h1;
               end
            end
         endcase
      end
      n.tx_en = ~hdx | (n.hst == HDX_SEND);

      // rts pin: direction in half duplex, else modem bit gated by fill
      rts_act = hdx ? (n.hst != HDX_IDLE) : (s.modem[MODEM_RTS] & ~n.rts_off);
      n.rts_n = ~rts_act;
      if (~s.rts_n & n.rts_n & s.int_en[IE_RTS] & s.feat[FEAT_GATE]) begin
         n.sts_flow = 1'b1;
      end
      n.cts_prev = I_CTS_N;
      if (I_CTS_N & ~s.cts_prev & s.int_en[IE_CTS] & s.feat[FEAT_GATE]) begin
         n.sts_flow = 1'b1;
      end

      // hold is a level, transmitter finishes its frame first
      n.tx_hold = (s.feat[FEAT_AUTO_CTS] & I_CTS_N) | n.paused;

      // pause/resume character generation
      if (s.snd_v & I_FC_DONE) begin
         n.snd_c0  = s.snd_c1;
         n.snd_two = 1'b0;
         n.snd_v   = s.snd_two;
      end
      if (!s.feat[FEAT_TX_SEND]) begin
         n.sent = 1'b0;
         n.xcnt = 5'h00;
      end else if (!s.sent) begin
         if (I_RX_LEVEL < PAUSE_LVL[trig]) begin
            n.xcnt = 5'h00;
         end else if (s.xcnt >= two_chars) begin
            if (!s.snd_v) begin
               n.snd_v   = 1'b1;
               n.snd_two = s.feat[FEAT_TX_DBL];
               n.snd_c0  = s.pau1;
               n.snd_c1  = s.pau2;
               n.sent    = 1'b1;
               n.xcnt    = 5'h00;
            end
         end else if (I_TX_TICK) begin
            n.xcnt = s.xcnt + 5'h01;
         end
      end else if (I_RX_LEVEL <= RESUME_LVL[trig] & ~s.snd_v) begin
         n.snd_v   = 1'b1;
         n.snd_two = s.feat[FEAT_TX_DBL];
         n.snd_c0  = s.res1;
         n.snd_c1  = s.res2;
         n.sent    = 1'b0;
      end

      // empty event source moves to the shift register in half duplex
      n.tx_empty = hdx ? I_SHIFT_EMPTY : I_HOLD_EMPTY;
      n.irq      = n.sts_flow | n.sts_char;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // all registers zero on reset except rts_n and tx_en, pin idles high
   always_ff @(posedge I_REF_CLK) begin
      if (I_SYS_RST) begin
         s         <= '0;
         s.feat    <= RESET_BYTE;
         s.res1    <= RESET_BYTE;
         s.res2    <= RESET_BYTE;
         s.pau1    <= RESET_BYTE;
         s.pau2    <= RESET_BYTE;
         s.rts_n   <= 1'b1;
         s.tx_en   <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flops
   // ----------------------------------------------------------------
   assign PRDATA      = s.prdata;
   assign PREADY      = s.pready;
   assign PSLVERR     = s.pslverr;
   assign O_RX_CHAR   = s.rx_out;
   assign O_FC_SEND   = '{valid: s.snd_v, data: s.snd_c0};
   assign O_RTS_N     = s.rts_n;
   assign O_TX_HOLD   = s.tx_hold;
   assign O_TX_ENABLE = s.tx_en;
   assign O_TX_EMPTY  = s.tx_empty;
   assign O_IRQ       = s.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   rts_off_hi_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (s.feat[FEAT_AUTO_RTS] & s.modem[MODEM_RTS] & ~s.fctl[FCTL_HDX]
       & I_RX_LEVEL >= RTS_OFF_LVL[s.fctl[1:0]]) |=> O_RTS_N)
      else $error("rts not released at upper fill");

   rts_on_lo_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (s.feat[FEAT_AUTO_RTS] & s.modem[MODEM_RTS] & ~s.fctl[FCTL_HDX]
       & I_RX_LEVEL <= RTS_ON_LVL[s.fctl[1:0]]) |=> !O_RTS_N)
      else $error("rts not asserted at lower fill");

   rts_manual_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (~s.feat[FEAT_AUTO_RTS] & ~s.fctl[FCTL_HDX] & ~wr) |=> O_RTS_N == !$past(s.modem[1]))
      else $error("rts not following modem bit");

   cts_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (s.feat[FEAT_AUTO_CTS] & I_CTS_N) |=> O_TX_HOLD)
      else $error("transmitter not held on cts");

   cts_irq_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (I_CTS_N & ~s.cts_prev & s.int_en[IE_CTS] & s.feat[FEAT_GATE]) |=> O_IRQ ##1 O_IRQ)
      else $error("cts rise gave no interrupt");

   rts_irq_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      ($rose(O_RTS_N) && $past(s.int_en[IE_RTS] & s.feat[FEAT_GATE])) |-> s.sts_flow)
      else $error("rts rise not flagged");

   pause_eat_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (I_RX_CHAR.valid & ~s.defer_v & s.feat[FEAT_RX_SW] & ~s.feat[FEAT_RX_DBL]
       & eq(I_RX_CHAR.data, s.pau1, mask)) |=> !O_RX_CHAR.valid && O_TX_HOLD)
      else $error("pause char stored or not obeyed");

   hdx_setup_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      (s.fctl[FCTL_HDX] && s.hst == HDX_SETUP) |-> !O_TX_ENABLE && !O_RTS_N)
      else $error("data enabled during setup delay");

   hdx_empty_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
      s.fctl[FCTL_HDX] |=> O_TX_EMPTY == $past(I_SHIFT_EMPTY))
      else $error("empty event not from shift register");

endmodule // ufc_flow

// file: tb/ufc_far_model.sv
// remote side: transmitter bit clock, flow character sender, remote CTS
module ufc_far_model (
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire ufc_pkg::ufc_char_t i_fc_send,
   input  wire logic               i_slow,
   input  wire logic               i_cts_stop,
   output logic                    o_tx_tick,
   output logic                    o_fc_done,
   output logic                    o_cts_n
);
   timeunit 1ns;
   timeprecision 100ps;
   import ufc_pkg::*;

   logic [1:0] div_q;
   logic [3:0] cnt_q;
   logic       busy_q;

   // one bit time every four clocks; a slow send takes ten bit times
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         div_q     <= 2'h0;
         cnt_q     <= 4'h0;
         busy_q    <= 1'b0;
         o_tx_tick <= 1'b0;
         o_fc_done <= 1'b0;
         o_cts_n   <= 1'b0;
      end else begin
         div_q     <= div_q + 2'h1;
         o_tx_tick <= (div_q == 2'h3);
         o_cts_n   <= i_cts_stop; // remote pauses and restarts us
         o_fc_done <= 1'b0;
         // the done guard stops a second ack before the next char lands
         if (!busy_q && i_fc_send.valid && !o_fc_done) begin
            busy_q <= 1'b1;
            cnt_q  <= i_slow ? 4'hA : 4'h1;
         end else if (busy_q && o_tx_tick) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               busy_q    <= 1'b0;
               o_fc_done <= 1'b1;
            end
         end
      end
   end
endmodule // ufc_far_model

// file: tb/ufc_flow_tb.sv
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end

module ufc_flow_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import ufc_pkg::*;

   logic        clk, rst, psel, pen, pwr, pready, pslverr, rerr;
   logic        tload, tidle, thre, tsre, slow, cstop;
   logic        tick, fdone, cts_n, rts_n, hold, ten, temp, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [6:0]  lvl;
   ufc_char_t   rxc, rxo, fcs, fwd;
   int          bad_count, checks_done, n;
   int          hi[4] = '{16, 56, 60, 60};
   int          lo[4] = '{0, 8, 16, 56};

   // ----------------------------------------------------------------
   // clock, design and remote side
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   ufc_flow i_dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .I_RX_CHAR(rxc), .I_RX_LEVEL(lvl), .I_CTS_N(cts_n),
      .I_TX_TICK(tick), .I_TX_LOAD(tload), .I_TX_IDLE(tidle), .I_HOLD_EMPTY(thre),
      .I_SHIFT_EMPTY(tsre), .I_FC_DONE(fdone), .O_RX_CHAR(rxo), .O_FC_SEND(fcs),
      .O_RTS_N(rts_n), .O_TX_HOLD(hold), .O_TX_ENABLE(ten), .O_TX_EMPTY(temp),
      .O_IRQ(irq));

   ufc_far_model i_far (.i_clk(clk), .i_rst(rst), .i_fc_send(fcs), .i_slow(slow),
      .i_cts_stop(cstop), .o_tx_tick(tick), .o_fc_done(fdone), .o_cts_n(cts_n));

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      // pready is read as it stands at the rising edge, before that edge updates it
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         bad_count++;
         close_out();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK("register read", {24'h0, e}, rdat)
   endtask

   // settle on a falling edge so sampled outputs are stable
   task automatic tk(input int c);
      repeat (c) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic lv(input logic [6:0] x);
      @(posedge clk);
      lvl <= x;
      tk(3);
   endtask

   // one received character; forwarded char sampled the cycle after
   task automatic rx(input logic [7:0] c);
      @(posedge clk);
      rxc <= '{valid: 1'b1, data: c};
      @(posedge clk);
      rxc.valid <= 1'b0;
      @(negedge clk);
      fwd = rxo;
   endtask

   // count bit ticks until an event; a tick in the event cycle is not counted;
   // caller stands on a falling edge, so the tick seen there is counted too
   task automatic ticks(input int w, output int c);
      int   i;
      logic ev;
      c = 0;
      for (i = 0; i < 400; i++) begin
         case (w)
            0: ev = ten;
            1: ev = rts_n;
            2: ev = fcs.valid;
            default: ev = !fcs.valid;
         endcase
         if (ev === 1'b1) break;
         if (tick === 1'b1) c++;
         @(negedge clk);
      end
      if (i == 400) begin
         bad_count++;
         close_out();
      end
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      bad_count = 0;
      checks_done = 0;
      {rst, tidle, thre, tsre} = 4'hF;
      {psel, pen, pwr, tload, slow, cstop} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      rxc = '0;
      lvl = 7'h00;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      tk(0);
      `CHK("rts idle", 1'b1, rts_n)
      for (int k = 0; k < 11; k++) rdchk(8'(4 * k), 8'h00);
      wr(PAUSE1_OFF, 8'hA5);
      rdchk(PAUSE1_OFF, 8'hA5);
      apb(1'b0, 8'h30, 8'h00);
      `CHK("unmapped error", 1'b1, rerr)
      $display("test registers done");
      // auto rts hysteresis over every trigger select
      wr(MODEM_OFF, 8'h02);
      lv(7'h3C);
      `CHK("rts manual", 1'b0, rts_n)
      wr(INT_EN_OFF, 8'h40);
      wr(FEAT_OFF, 8'h50);
      lv(7'h00); // hysteresis must start from rts on
      for (int t = 0; t < 4; t++) begin
         wr(FCTL_OFF, 8'(t));
         lv(7'(hi[t] - 1));
         `CHK("rts below upper", 1'b0, rts_n)
         lv(7'(hi[t]));
         `CHK("rts at upper", 1'b1, rts_n)
         lv(7'(lo[t] + 1));
         `CHK("rts above lower", 1'b1, rts_n)
         lv(7'(lo[t]));
         `CHK("rts at lower", 1'b0, rts_n)
      end
      `CHK("rts irq", 1'b1, irq)
      rdchk(INT_ST_OFF, 8'h20);
      wr(INT_ST_OFF, 8'h20);
      wr(MODEM_OFF, 8'h00);
      lv(7'h00);
      `CHK("rts not started", 1'b1, rts_n)
      $display("test auto rts done");
      // auto cts
      wr(FEAT_OFF, 8'h00);
      wr(INT_EN_OFF, 8'h80);
      @(posedge clk);
      cstop <= 1'b1;
      tk(4);
      `CHK("hold cts off", 1'b0, hold)
      @(posedge clk);
      cstop <= 1'b0;
      wr(INT_ST_OFF, 8'h30);
      wr(FEAT_OFF, 8'h90);
      @(posedge clk);
      cstop <= 1'b1;
      tk(4);
      `CHK("hold cts", 1'b1, hold)
      `CHK("cts irq", 1'b1, irq)
      @(posedge clk);
      cstop <= 1'b0;
      tk(4);
      `CHK("resume cts", 1'b0, hold)
      wr(INT_ST_OFF, 8'h30);
      $display("test auto cts done");
      // software flow, word length, special character
      wr(LINE_OFF, 8'h03);
      wr(RESUME1_OFF, 8'h11);
      wr(PAUSE1_OFF, 8'h13);
      wr(INT_EN_OFF, 8'h20);
      wr(FEAT_OFF, 8'h11);
      rx(8'h41);
      `CHK("plain char", 9'h141, fwd)
      rx(8'h13);
      `CHK("pause eaten", 1'b0, fwd.valid)
      `CHK("pause hold", 1'b1, hold)
      `CHK("pause irq", 1'b1, irq)
      rx(8'h11);
      `CHK("resume hold", 1'b0, hold)
      `CHK("resume irq", 1'b0, irq)
      wr(LINE_OFF, 8'h00);
      rx(8'hF3);
      `CHK("short pause", 1'b1, hold)
      rx(8'hF1);
      `CHK("short resume", 1'b0, hold)
      wr(LINE_OFF, 8'h03);
      wr(PAUSE2_OFF, 8'h2A);
      wr(FEAT_OFF, 8'h30);
      rx(8'h2A);
      `CHK("special kept", 9'h12A, fwd)
      rdchk(INT_ST_OFF, 8'h10);
      wr(INT_ST_OFF, 8'h30);
      $display("test software flow done");
      // automatic pause and resume sending, slow remote
      wr(FCTL_OFF, 8'h00);
      wr(FEAT_OFF, 8'h14);
      @(posedge clk);
      slow <= 1'b1;
      lvl <= 7'h08;
      @(negedge clk);
      ticks(2, n);
      `CHK("pause delay", 1'b1, (n >= 19 && n <= 21))
      `CHK("pause sent", 9'h113, fcs)
      ticks(3, n);
      lv(7'h01);
      `CHK("no early resume", 1'b0, fcs.valid)
      @(posedge clk);
      lvl <= 7'h00;
      @(negedge clk);
      ticks(2, n);
      `CHK("resume sent", 9'h111, fcs)
      ticks(3, n);
      $display("test auto send done");
      // half duplex direction and delays
      wr(FEAT_OFF, 8'h00);
      wr(FCTL_OFF, 8'h08);
      wr(HDX_DLY_OFF, 8'h32);
      @(posedge clk);
      tsre <= 1'b0;
      tk(2);
      `CHK("empty from shift", 1'b0, temp)
      `CHK("dir idle", 1'b1, rts_n)
      @(posedge clk);
      tload <= 1'b1;
      tidle <= 1'b0;
      @(posedge clk);
      tload <= 1'b0;
      @(negedge clk);
      `CHK("dir on", 1'b0, rts_n)
      `CHK("setup gate", 1'b0, ten)
      ticks(0, n);
      `CHK("setup ticks", 3, n)
      @(posedge clk);
      tsre <= 1'b1;
      tidle <= 1'b1;
      // the sequencer leaves the send state one edge later; ticks before it do not count
      @(posedge clk);
      @(negedge clk);
      ticks(1, n);
      `CHK("turn ticks", 2, n)
      $display("test half duplex done");
      close_out();
   end
endmodule // ufc_flow_tb
